// File: dcd_pkg.sv
// dcd_pkg: constants and carrier types for the direct-command decoder.
// assumes a single 40 MHz clock domain and an AXI4-Lite master.
package dcd_pkg;
    // register byte offsets
    localparam logic [5:0] OFS_CMD = 6'h00;
    localparam logic [5:0] OFS_OPCTRL = 6'h04;
    localparam logic [5:0] OFS_MODECFG = 6'h08;
    localparam logic [5:0] OFS_IOCFG1 = 6'h0C;
    localparam logic [5:0] OFS_IOCFG2 = 6'h10;
    localparam logic [5:0] OFS_RXCFG1 = 6'h14;
    localparam logic [5:0] OFS_ADCOUT = 6'h18;
    localparam logic [5:0] OFS_STATUS = 6'h1C;
    localparam logic [5:0] OFS_GAIN = 6'h20;
    localparam logic [5:0] OFS_CALRES = 6'h24;
    // operation control fields
    localparam int OPC_EN_BIT = 7;
    localparam int OPC_RXEN_BIT = 6;
    localparam int OPC_TXEN_BIT = 3;
    localparam int OPC_WU_BIT = 2;
    // mode configuration fields
    localparam int MC_EXTREG_BIT = 0;
    localparam int MC_CSMCAL_BIT = 1;
    localparam int MC_NFCTGT_BIT = 2;
    // status fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_MASK_BIT = 1;
    localparam int ST_TEST_BIT = 2;
    // reset values
    localparam logic [7:0] RST_OPCTRL = 8'h00;
    localparam logic [7:0] RST_MODECFG = 8'h00;
    localparam logic [7:0] RST_IOCFG1 = 8'h00;
    localparam logic [7:0] RST_IOCFG2 = 8'h00;
    localparam logic [7:0] RST_RXCFG1 = 8'h00;
    localparam logic [7:0] RST_RESULT = 8'h00;
    // command codes
    localparam logic [7:0] CMD_SET_DEFAULT = 8'hC1;
    localparam logic [7:0] CMD_PRESET = 8'hCC;
    localparam logic [7:0] CMD_MASK_RX = 8'hD0;
    localparam logic [7:0] CMD_UNMASK_RX = 8'hD1;
    localparam logic [7:0] CMD_MEAS_AMP = 8'hD3;
    localparam logic [7:0] CMD_SQUELCH = 8'hD4;
    localparam logic [7:0] CMD_RESET_GAIN = 8'hD5;
    localparam logic [7:0] CMD_ADJ_REG = 8'hD6;
    localparam logic [7:0] CMD_CAL_MOD = 8'hD7;
    localparam logic [7:0] CMD_CAL_ANT = 8'hD8;
    localparam logic [7:0] CMD_MEAS_PHASE = 8'hD9;
    localparam logic [7:0] CMD_CLR_RSSI = 8'hDA;
    localparam logic [7:0] CMD_CAL_CS = 8'hDD;
    localparam logic [7:0] CMD_MEAS_CAP = 8'hDE;
    localparam logic [7:0] CMD_MEAS_SUPPLY = 8'hDF;
    localparam logic [7:0] CMD_TMR_GP = 8'hE0;
    localparam logic [7:0] CMD_TMR_WU = 8'hE1;
    localparam logic [7:0] CMD_TMR_MRX = 8'hE2;
    localparam logic [7:0] CMD_TMR_NR = 8'hE3;
    localparam logic [7:0] CMD_TEST = 8'hFC;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // one-cycle event outputs
    typedef struct packed {
        logic seq_start;
        logic seq_abort;
        logic term_irq;
        logic preset;
        logic rssi_clear;
        logic fifo_clear;
        logic unmask;
        logic tmr_gp;
        logic tmr_wu;
        logic tmr_mrx;
        logic tmr_nr;
        logic accept;
        logic reject;
    } dcd_pulse_t;

    typedef struct packed {
        logic aw_got;
        logic [5:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_strb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] opctrl;
        logic [7:0] mode_cfg;
        logic [7:0] io_cfg1;
        logic [7:0] io_cfg2;
        logic [7:0] rx_cfg1;
        logic [7:0] adc_out;
        logic [7:0] gain;
        logic [7:0] cal_res;
        logic [7:0] last_code;
        logic busy;
        logic [7:0] seq_code;
        logic seq_irq;
        logic rx_masked;
        logic test_access;
        dcd_pulse_t pulse;
    } dcd_state_t;
endpackage : dcd_pkg

// File: dcd_top.sv
// dcd_top: direct-command decoder with acceptance checks and register file.
// assumes an AXI4-Lite master on CLOCK_I and an analog sequencer that
// answers each SEQ_START_O with one SEQ_DONE_I pulse carrying a result.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcd_top
    import dcd_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    // axi4-lite write response
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    // analog sequencer
    output logic SEQ_START_O,
    output logic SEQ_ABORT_O,
    output logic [7:0] SEQ_CODE_O,
    input wire logic SEQ_DONE_I,
    input wire logic [7:0] SEQ_RESULT_I,
    // events and levels towards the rest of the front end
    output logic TERM_IRQ_O,
    output logic PRESET_O,
    output logic RSSI_CLEAR_O,
    output logic FIFO_CLEAR_O,
    output logic RX_UNMASK_O,
    output logic RX_MASK_O,
    output logic TEST_WR_EN_O,
    output logic [7:0] RX_GAIN_O,
    output logic TMR_GP_START_O,
    output logic TMR_WU_START_O,
    output logic TMR_MRX_START_O,
    output logic TMR_NR_START_O,
    output logic CMD_ACCEPT_O,
    output logic CMD_REJECT_O
);
    // the register map needs six address bits
    if (ADDR_W < 6) begin : g_addr_check
        $error("dcd_top: ADDR_W must be at least 6");
    end

    dcd_state_t s_q;
    dcd_state_t s_d;
    logic cmd_fire;
    logic [7:0] code;
    logic known;
    logic ok;

    // unknown codes are filtered before acceptance so they touch nothing
    function automatic logic dcd_known(input logic [7:0] c);
        unique case (c)
            CMD_SET_DEFAULT, CMD_PRESET, CMD_MASK_RX, CMD_UNMASK_RX,
            CMD_MEAS_AMP, CMD_SQUELCH, CMD_RESET_GAIN, CMD_ADJ_REG,
            CMD_CAL_MOD, CMD_CAL_ANT, CMD_MEAS_PHASE, CMD_CLR_RSSI,
            CMD_CAL_CS, CMD_MEAS_CAP, CMD_MEAS_SUPPLY, CMD_TMR_GP,
            CMD_TMR_WU, CMD_TMR_MRX, CMD_TMR_NR, CMD_TEST: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : dcd_known

    function automatic logic dcd_accept(input logic [7:0] c,
                                        input logic [7:0] op,
                                        input logic [7:0] mc);
        logic en;
        logic rx;
        en = op[OPC_EN_BIT];
        rx = op[OPC_RXEN_BIT];
        unique case (c)
            CMD_SET_DEFAULT, CMD_PRESET, CMD_TEST, CMD_MEAS_CAP: return 1'b1;
            CMD_MASK_RX, CMD_UNMASK_RX, CMD_SQUELCH,
            CMD_TMR_NR: return en & rx;
            CMD_ADJ_REG: return en & ~mc[MC_EXTREG_BIT];
            CMD_CAL_CS: return ~mc[MC_CSMCAL_BIT];
            CMD_TMR_WU: return ~op[OPC_WU_BIT];
            CMD_TMR_MRX: return mc[MC_NFCTGT_BIT];
            default: return en;
        endcase
    endfunction : dcd_accept

    // non-chainable commands run as sequences; only those raise the flag
    function automatic logic dcd_is_seq(input logic [7:0] c);
        unique case (c)
            CMD_MEAS_AMP, CMD_SQUELCH, CMD_ADJ_REG, CMD_CAL_MOD, CMD_CAL_ANT,
            CMD_MEAS_PHASE, CMD_CAL_CS, CMD_MEAS_CAP,
            CMD_MEAS_SUPPLY: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : dcd_is_seq

    function automatic logic [7:0] dcd_status(input dcd_state_t s);
        logic [7:0] v;
        v = 8'h00;
        v[ST_BUSY_BIT] = s.busy;
        v[ST_MASK_BIT] = s.rx_masked;
        v[ST_TEST_BIT] = s.test_access;
        return v;
    endfunction : dcd_status

    assign cmd_fire = s_q.aw_got & s_q.w_got & ~s_q.bvalid & s_q.w_strb0 &
                      (s_q.aw_addr == OFS_CMD);
    assign code = s_q.w_data;
    assign known = dcd_known(code);
    assign ok = dcd_accept(code, s_q.opctrl, s_q.mode_cfg);

    always_comb begin
        logic [5:0] ra;
        logic rhit;
        logic [7:0] rv;
        logic wr;
        ra = ARADDR_I[5:0];
        rhit = 1'b1;
        rv = 8'h00;
        wr = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
        s_d = s_q;
        s_d.pulse = '0;

        // write channel: address and data taken in either order
        if (AWVALID_I && !s_q.aw_got) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = AWADDR_I[5:0];
        end
        if (WVALID_I && !s_q.w_got) begin
            s_d.w_got = 1'b1;
            s_d.w_data = WDATA_I[7:0];
            s_d.w_strb0 = WSTRB_I[0];
        end
        if (s_q.bvalid && BREADY_I) begin
            s_d.bvalid = 1'b0;
        end
        if (wr) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            unique case (s_q.aw_addr)
                OFS_OPCTRL: begin
                    if (s_q.w_strb0) s_d.opctrl = s_q.w_data;
                end
                OFS_MODECFG: begin
                    if (s_q.w_strb0) s_d.mode_cfg = s_q.w_data;
                end
                OFS_IOCFG1: begin
                    if (s_q.w_strb0) s_d.io_cfg1 = s_q.w_data;
                end
                OFS_IOCFG2: begin
                    if (s_q.w_strb0) s_d.io_cfg2 = s_q.w_data;
                end
                OFS_RXCFG1: begin
                    if (s_q.w_strb0) s_d.rx_cfg1 = s_q.w_data;
                end
                OFS_CMD, OFS_ADCOUT, OFS_STATUS, OFS_GAIN, OFS_CALRES: begin
                end
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end

        // sequence completion; results are only stored for the running code
        if (s_q.busy && SEQ_DONE_I) begin
            s_d.busy = 1'b0;
            s_d.pulse.term_irq = s_q.seq_irq;
            unique case (s_q.seq_code)
                CMD_MEAS_AMP, CMD_MEAS_PHASE, CMD_MEAS_CAP,
                CMD_MEAS_SUPPLY: s_d.adc_out = SEQ_RESULT_I;
                CMD_SQUELCH: s_d.gain = SEQ_RESULT_I;
                default: s_d.cal_res = SEQ_RESULT_I;
            endcase
        end

        // command decode; a running sequence blocks all but set default
        if (cmd_fire && known) begin
            if (!ok || (s_q.busy && code != CMD_SET_DEFAULT)) begin
                s_d.pulse.reject = 1'b1;
            end else begin
                s_d.pulse.accept = 1'b1;
                s_d.last_code = code;
                if (dcd_is_seq(code)) begin
                    s_d.busy = 1'b1;
                    s_d.seq_code = code;
                    s_d.seq_irq = (code != CMD_SQUELCH);
                    s_d.pulse.seq_start = 1'b1;
                end
                unique case (code)
                    CMD_SET_DEFAULT: begin
                        // keep io config and opctrl
                        s_d.mode_cfg = RST_MODECFG;
                        s_d.rx_cfg1 = RST_RXCFG1;
                        s_d.adc_out = RST_RESULT;
                        s_d.gain = RST_RESULT;
                        s_d.cal_res = RST_RESULT;
                        s_d.last_code = RST_RESULT;
                        s_d.rx_masked = 1'b0;
                        s_d.test_access = 1'b0;
                        s_d.busy = 1'b0;
                        s_d.seq_irq = 1'b0;
                        s_d.pulse.seq_abort = s_q.busy;
                        s_d.pulse.term_irq = 1'b0;
                        s_d.pulse.fifo_clear = s_q.opctrl[OPC_EN_BIT];
                    end
                    CMD_PRESET: s_d.pulse.preset = 1'b1;
                    CMD_MASK_RX: s_d.rx_masked = 1'b1;
                    CMD_UNMASK_RX: begin
                        s_d.rx_masked = 1'b0;
                        s_d.pulse.unmask = 1'b1;
                    end
                    CMD_RESET_GAIN: s_d.gain = s_q.rx_cfg1;
                    CMD_CLR_RSSI: s_d.pulse.rssi_clear = 1'b1;
                    CMD_TMR_GP: s_d.pulse.tmr_gp = 1'b1;
                    CMD_TMR_WU: s_d.pulse.tmr_wu = 1'b1;
                    CMD_TMR_MRX: s_d.pulse.tmr_mrx = 1'b1;
                    CMD_TMR_NR: s_d.pulse.tmr_nr = 1'b1;
                    CMD_TEST: s_d.test_access = 1'b1;
                    default: begin
                    end
                endcase
            end
        end

        // read channel: one cycle from address to data
        unique case (ra)
            OFS_CMD: rv = s_q.last_code;
            OFS_OPCTRL: rv = s_q.opctrl;
            OFS_MODECFG: rv = s_q.mode_cfg;
            OFS_IOCFG1: rv = s_q.io_cfg1;
            OFS_IOCFG2: rv = s_q.io_cfg2;
            OFS_RXCFG1: rv = s_q.rx_cfg1;
            OFS_ADCOUT: rv = s_q.adc_out;
            OFS_STATUS: rv = dcd_status(s_q);
            OFS_GAIN: rv = s_q.gain;
            OFS_CALRES: rv = s_q.cal_res;
            default: rhit = 1'b0;
        endcase
        if (s_q.rvalid && RREADY_I) begin
            s_d.rvalid = 1'b0;
        end
        if (ARVALID_I && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rv;
            s_d.rresp = rhit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            s_q <= '0;
            s_q.opctrl <= RST_OPCTRL;
            s_q.mode_cfg <= RST_MODECFG;
            s_q.io_cfg1 <= RST_IOCFG1;
            s_q.io_cfg2 <= RST_IOCFG2;
            s_q.rx_cfg1 <= RST_RXCFG1;
        end else begin
            s_q <= s_d;
        end
    end

    // the write path holds one address and one data word; ready drops
    // while a word waits, which keeps a single write in flight
    assign AWREADY_O = ~s_q.aw_got;
    assign WREADY_O = ~s_q.w_got;
    assign BVALID_O = s_q.bvalid;
    assign BRESP_O = s_q.bresp;
    assign ARREADY_O = ~s_q.rvalid;
    assign RVALID_O = s_q.rvalid;
    assign RDATA_O = {24'h00_0000, s_q.rdata};
    assign RRESP_O = s_q.rresp;
    assign SEQ_START_O = s_q.pulse.seq_start;
    assign SEQ_ABORT_O = s_q.pulse.seq_abort;
    assign SEQ_CODE_O = s_q.seq_code;
    assign TERM_IRQ_O = s_q.pulse.term_irq;
    assign PRESET_O = s_q.pulse.preset;
    assign RSSI_CLEAR_O = s_q.pulse.rssi_clear;
    assign FIFO_CLEAR_O = s_q.pulse.fifo_clear;
    assign RX_UNMASK_O = s_q.pulse.unmask;
    assign RX_MASK_O = s_q.rx_masked;
    assign TEST_WR_EN_O = s_q.test_access;
    assign RX_GAIN_O = s_q.gain;
    assign TMR_GP_START_O = s_q.pulse.tmr_gp;
    assign TMR_WU_START_O = s_q.pulse.tmr_wu;
    assign TMR_MRX_START_O = s_q.pulse.tmr_mrx;
    assign TMR_NR_START_O = s_q.pulse.tmr_nr;
    assign CMD_ACCEPT_O = s_q.pulse.accept;
    assign CMD_REJECT_O = s_q.pulse.reject;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);

    chk_preset_pulse: assert property (
        cmd_fire && code == CMD_PRESET && !s_q.busy |=> PRESET_O && !TERM_IRQ_O)
        else $error("preset not issued");
    chk_unmask_clears: assert property (
        cmd_fire && code == CMD_UNMASK_RX && ok && !s_q.busy
        |=> !RX_MASK_O && RX_UNMASK_O)
        else $error("unmask did not clear mask");
    chk_amp_enable: assert property (
        cmd_fire && code == CMD_MEAS_AMP && !s_q.opctrl[OPC_EN_BIT]
        |=> CMD_REJECT_O && !SEQ_START_O)
        else $error("amplitude measure ran without enable");
    chk_gain_load: assert property (
        cmd_fire && code == CMD_RESET_GAIN && ok && !s_q.busy
        |=> RX_GAIN_O == $past(s_q.rx_cfg1))
        else $error("manual gain not loaded");
    chk_extreg_reject: assert property (
        cmd_fire && code == CMD_ADJ_REG && s_q.mode_cfg[MC_EXTREG_BIT] &&
        !s_q.busy |=> CMD_REJECT_O && !SEQ_START_O ##1 !TERM_IRQ_O)
        else $error("regulator adjust accepted with external select");
    chk_done_irq: assert property (
        s_q.busy && SEQ_DONE_I && s_q.seq_irq && !cmd_fire
        |=> TERM_IRQ_O && !s_q.busy)
        else $error("completion interrupt missing");
    chk_timer_noirq: assert property (
        TMR_GP_START_O || TMR_WU_START_O || TMR_MRX_START_O || TMR_NR_START_O
        |-> !SEQ_START_O && !s_q.busy && !TERM_IRQ_O)
        else $error("timer start raised a sequence");
    chk_setdef_keep: assert property (
        cmd_fire && code == CMD_SET_DEFAULT
        |=> $stable(s_q.opctrl) && $stable(s_q.io_cfg1) && s_q.cal_res == 8'h00)
        else $error("set default touched protected registers");
    chk_fifo_keep: assert property (
        cmd_fire && code == CMD_SET_DEFAULT && !s_q.opctrl[OPC_EN_BIT]
        |=> !FIFO_CLEAR_O && !TERM_IRQ_O)
        else $error("fifo cleared with enable low");
    chk_busy_block: assert property (
        cmd_fire && s_q.busy && code != CMD_SET_DEFAULT && known &&
        !SEQ_DONE_I |=> !CMD_ACCEPT_O && CMD_REJECT_O && $stable(s_q.gain))
        else $error("command accepted during sequence");
    chk_unused_quiet: assert property (
        cmd_fire && !known |=> !CMD_ACCEPT_O && !CMD_REJECT_O)
        else $error("unused code had an effect");
    chk_write_answer: assert property (
        s_q.aw_got && s_q.w_got && !s_q.bvalid |=> BVALID_O)
        else $error("write response late");

    cov_seq_done: cover property (SEQ_START_O ##[1:20] TERM_IRQ_O);
    cov_setdef_abort: cover property (SEQ_ABORT_O);
    cov_reject: cover property (CMD_REJECT_O);
    cov_mask_unmask: cover property (RX_MASK_O ##[1:50] RX_UNMASK_O);
endmodule : dcd_top
`default_nettype wire

// File: dcd_seq_model.sv
// dcd_seq_model: behavioural analog sequencer on the decoder's far side.
// assumes start and abort are one-cycle pulses, code held with start.
`timescale 1ns/1ps
`default_nettype none
module dcd_seq_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // requests from the decoder
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic [7:0] code_i,
    // answer
    output logic done_o,
    output logic [7:0] result_o
);
    logic [7:0] cnt_q;
    logic [7:0] res_q;
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        // result is only meaningful with done, so it wanders otherwise
        result_o <= ~result_o;
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
            result_o <= 8'h00;
        end else if (abort_i) begin
            cnt_q <= 8'h00;
        end else if (start_i) begin
            // odd codes answer fast, even codes slowly
            cnt_q <= code_i[0] ? 8'h04 : 8'h28;
            res_q <= code_i ^ 8'hA5;
        end else if (cnt_q == 8'h01) begin
            done_o <= 1'b1;
            result_o <= res_q;
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule : dcd_seq_model
`default_nettype wire

// File: tb_top.sv
// tb_top: self-checking bench for the direct-command decoder.
// assumes dcd_top and dcd_seq_model; 40 MHz clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dcd_pkg::*;
    logic CLOCK_I, RESET_N_I, AWVALID_I, WVALID_I, BREADY_I;
    logic ARVALID_I, RREADY_I, SEQ_DONE_I;
    logic [5:0] AWADDR_I, ARADDR_I;
    logic [31:0] WDATA_I, RDATA_O;
    logic [3:0] WSTRB_I;
    logic [7:0] SEQ_RESULT_I, SEQ_CODE_O, RX_GAIN_O;
    logic [1:0] BRESP_O, RRESP_O;
    logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
    logic SEQ_START_O, SEQ_ABORT_O, TERM_IRQ_O, PRESET_O, RSSI_CLEAR_O;
    logic FIFO_CLEAR_O, RX_UNMASK_O, RX_MASK_O, TEST_WR_EN_O;
    logic TMR_GP_START_O, TMR_WU_START_O, TMR_MRX_START_O, TMR_NR_START_O;
    logic CMD_ACCEPT_O, CMD_REJECT_O;
    int mismatches, checked, n_acc, n_rej, n_irq, n_fc, n_pre;
    int n_st, n_ab, n_ev;
    logic [31:0] rdat;
    logic [1:0] rrsp;
    dcd_top dut_u (.*);
    dcd_seq_model seq_u (.clk_i(CLOCK_I), .rst_n_i(RESET_N_I),
        .start_i(SEQ_START_O), .abort_i(SEQ_ABORT_O), .code_i(SEQ_CODE_O),
        .done_o(SEQ_DONE_I), .result_o(SEQ_RESULT_I));
    initial begin
        CLOCK_I = 1'b0;
        forever #12.5 CLOCK_I = ~CLOCK_I;
    end
    // pulses are tallied mid-cycle, where they stand settled
    always @(negedge CLOCK_I) begin
        n_acc += (CMD_ACCEPT_O === 1'b1);
        n_rej += (CMD_REJECT_O === 1'b1);
        n_irq += (TERM_IRQ_O === 1'b1);
        n_fc += (FIFO_CLEAR_O === 1'b1);
        n_pre += (PRESET_O === 1'b1);
        n_st += (SEQ_START_O === 1'b1);
        n_ab += (SEQ_ABORT_O === 1'b1);
        n_ev += (RX_UNMASK_O === 1'b1) + (RSSI_CLEAR_O === 1'b1) +
            (TMR_GP_START_O === 1'b1) + (TMR_WU_START_O === 1'b1) +
            (TMR_MRX_START_O === 1'b1) + (TMR_NR_START_O === 1'b1);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic ad, wd, b;
        ad = 1'b0;
        wd = 1'b0;
        AWADDR_I <= a;
        WDATA_I <= {24'h00_0000, d};
        AWVALID_I <= 1'b1;
        WVALID_I <= 1'b1;
        BREADY_I <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge CLOCK_I);
            if (AWREADY_O === 1'b1) ad = 1'b1;
            if (WREADY_O === 1'b1) wd = 1'b1;
            @(posedge CLOCK_I);
            if (ad) AWVALID_I <= 1'b0;
            if (wd) WVALID_I <= 1'b0;
        end
        do begin
            @(negedge CLOCK_I);
            b = (BVALID_O === 1'b1);
            @(posedge CLOCK_I);
        end while (!b);
        BREADY_I <= 1'b0;
        @(posedge CLOCK_I);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        logic ad, r;
        ad = 1'b0;
        ARADDR_I <= a;
        ARVALID_I <= 1'b1;
        RREADY_I <= 1'b1;
        while (!ad) begin
            @(negedge CLOCK_I);
            ad = (ARREADY_O === 1'b1);
            @(posedge CLOCK_I);
        end
        ARVALID_I <= 1'b0;
        do begin
            @(negedge CLOCK_I);
            r = (RVALID_O === 1'b1);
            rdat = RDATA_O;
            rrsp = RRESP_O;
            @(posedge CLOCK_I);
        end while (!r);
        RREADY_I <= 1'b0;
        @(posedge CLOCK_I);
    endtask : rd
    task automatic wait_irq(input int k);
        for (int i = 0; i < 400 && n_irq < k; i++) @(posedge CLOCK_I);
    endtask : wait_irq
    task automatic t_reject();
        int a, r;
        rd(OFS_OPCTRL);
        chk(rdat, 32'h0000_0000);
        rd(6'h3C);
        chk(rrsp, RESP_SLVERR);
        a = n_acc;
        r = n_rej;
        wr(OFS_CMD, CMD_MEAS_AMP);
        chk(n_rej, r + 1);
        chk(n_st, 0);
        wr(OFS_CMD, 8'hD2);
        chk(n_acc + n_rej, a + r + 1);
        wr(OFS_CMD, 8'hF0);
        chk(n_acc + n_rej, a + r + 1);
        wr(OFS_CMD, CMD_PRESET);
        chk(n_pre, 1);
    endtask : t_reject
    task automatic t_chain();
        int a;
        wr(OFS_OPCTRL, 8'hC0);
        wr(OFS_CMD, CMD_MASK_RX);
        chk(RX_MASK_O, 1'b1);
        wr(OFS_CMD, CMD_UNMASK_RX);
        chk(RX_MASK_O, 1'b0);
        a = n_acc;
        wr(OFS_CMD, CMD_TMR_GP);
        wr(OFS_CMD, CMD_TMR_NR);
        wr(OFS_CMD, CMD_CLR_RSSI);
        wr(OFS_CMD, CMD_TMR_WU);
        chk(n_acc, a + 4);
        chk(n_ev, 5);
        wr(OFS_CMD, CMD_TEST);
        chk(TEST_WR_EN_O, 1'b1);
        rd(OFS_CMD);
        chk(rdat, {24'h00_0000, CMD_TEST});
    endtask : t_chain
    task automatic t_seq();
        int r;
        wr(OFS_CMD, CMD_MEAS_AMP);
        wait_irq(1);
        rd(OFS_ADCOUT);
        chk(rdat, {24'h00_0000, CMD_MEAS_AMP ^ 8'hA5});
        r = n_rej;
        wr(OFS_CMD, CMD_CAL_ANT);
        chk(SEQ_CODE_O, CMD_CAL_ANT);
        wr(OFS_CMD, CMD_TMR_GP);
        chk(n_rej, r + 1);
        wait_irq(2);
        rd(OFS_CALRES);
        chk(rdat, {24'h00_0000, CMD_CAL_ANT ^ 8'hA5});
    endtask : t_seq
    task automatic t_mode();
        int r;
        r = n_rej;
        wr(OFS_MODECFG, 8'h01);
        wr(OFS_CMD, CMD_ADJ_REG);
        wr(OFS_CMD, CMD_TMR_MRX);
        chk(n_rej, r + 2);
        wr(OFS_MODECFG, 8'h04);
        wr(OFS_CMD, CMD_TMR_MRX);
        chk(n_rej, r + 2);
        chk(n_ev, 6);
        wr(OFS_CMD, CMD_MEAS_PHASE);
        wait_irq(3);
        rd(OFS_ADCOUT);
        chk(rdat, {24'h00_0000, CMD_MEAS_PHASE ^ 8'hA5});
    endtask : t_mode
    task automatic t_default();
        int i;
        wr(OFS_RXCFG1, 8'h33);
        wr(OFS_CMD, CMD_RESET_GAIN);
        chk(RX_GAIN_O, 8'h33);
        wr(OFS_IOCFG1, 8'h11);
        i = n_irq;
        // a slow squelch is still running when set default arrives
        wr(OFS_CMD, CMD_SQUELCH);
        rd(OFS_STATUS);
        chk(rdat, 32'h0000_0005);
        wr(OFS_CMD, CMD_SET_DEFAULT);
        chk(n_fc, 1);
        chk(n_ab, 1);
        repeat (50) @(posedge CLOCK_I);
        chk(n_irq, i);
        chk(RX_GAIN_O, 8'h00);
        chk(TEST_WR_EN_O, 1'b0);
        rd(OFS_RXCFG1);
        chk(rdat, 32'h0000_0000);
        rd(OFS_CALRES);
        chk(rdat, 32'h0000_0000);
        rd(OFS_IOCFG1);
        chk(rdat, 32'h0000_0011);
        rd(OFS_OPCTRL);
        chk(rdat, 32'h0000_00C0);
        wr(OFS_OPCTRL, 8'h00);
        wr(OFS_CMD, CMD_SET_DEFAULT);
        chk(n_fc, 1);
        wr(OFS_CMD, CMD_MEAS_CAP);
        wait_irq(i + 1);
        chk(n_irq, i + 1);
        rd(OFS_ADCOUT);
        chk(rdat, {24'h00_0000, CMD_MEAS_CAP ^ 8'hA5});
    endtask : t_default
    task automatic results();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    initial begin
        {RESET_N_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I} = 5'h00;
        {RREADY_I, AWADDR_I, ARADDR_I, WDATA_I} = 45'h0;
        WSTRB_I = 4'hF;
        repeat (20) @(posedge CLOCK_I);
        RESET_N_I <= 1'b1;
        @(posedge CLOCK_I);
        t_reject();
        t_chain();
        t_seq();
        t_mode();
        t_default();
        results();
    end
    // the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge CLOCK_I);
        mismatches++;
        results();
    end
endmodule : tb_top
`default_nettype wire
